/* File: design/acsc_pkg.sv */
/*
 * Shared constants, field layouts and the amplitude lookup for the gain control
 * and carrier sense configuration bank.
 * Assumes a single device clock and a byte-wide register port fed by the serial control logic.
 */
package acsc_pkg;

	// Register addresses
	localparam logic [7:0] ADDR_FREQ_OFFSET = 8'h19;
	localparam logic [7:0] ADDR_BIT_SYNC = 8'h1a;
	localparam logic [7:0] ADDR_GAIN_LIMITS = 8'h1b;
	localparam logic [7:0] ADDR_CARRIER_SENSE = 8'h1c;

	// Reset values
	localparam logic [7:0] RST_FREQ_OFFSET = 8'h36;
	localparam logic [7:0] RST_BIT_SYNC = 8'h6c;
	localparam logic [7:0] RST_GAIN_LIMITS = 8'h03;
	localparam logic [7:0] RST_CARRIER_SENSE = 8'h40;

	// Writable bit masks; everything else is reserved
	localparam logic [7:0] MASK_FREQ_OFFSET = 8'h3f;
	localparam logic [7:0] MASK_CARRIER_SENSE = 8'h7f;

	typedef struct packed {
		logic [1:0] digital_gain_ceiling;
		logic [2:0] amplifier_gain_ceiling;
		logic [2:0] amplitude_target;
	} acsc_limits_t;

	typedef struct packed {
		logic reserved;
		logic gain_reduction_order;
		logic [1:0] cs_relative_threshold;
		logic [3:0] cs_absolute_threshold;
	} acsc_csense_t;

	typedef struct packed {
		logic [2:0] digital_variable_amp;
		logic [2:0] low_noise_amp1;
		logic [2:0] low_noise_amp2;
	} acsc_gain_t;

	// Gain step ranges
	localparam logic [2:0] GAIN_STEP_MAX = 3'h7;
	localparam logic [2:0] GAIN_STEP_MIN = 3'h0;
	localparam logic [3:0] LNA_SUM_MAX = 4'he;
	localparam logic [3:0] LNA_CAP_STEP = 4'h2;

	// Carrier sense encodings
	localparam logic [3:0] ABS_THR_DISABLED = 4'h8;
	localparam logic [1:0] REL_THR_DISABLED = 2'h0;
	localparam logic [7:0] REL_RISE_DB1 = 8'h06;
	localparam logic [7:0] REL_RISE_DB2 = 8'h0a;
	localparam logic [7:0] REL_RISE_DB3 = 8'h0e;

	// Clear channel selection
	localparam logic [1:0] CCA_ALWAYS = 2'h0;
	localparam logic [1:0] CCA_RSSI = 2'h1;
	localparam logic [1:0] CCA_NO_PACKET = 2'h2;
	localparam logic [1:0] CCA_RSSI_NO_PACKET = 2'h3;

	function automatic logic [7:0] acsc_target_db(input logic [2:0] code);
		logic [7:0] db;
		db = 8'h18;
		case (code)
			3'h0: db = 8'h18;
			3'h1: db = 8'h1b;
			3'h2: db = 8'h1e;
			3'h3: db = 8'h21;
			3'h4: db = 8'h24;
			3'h5: db = 8'h26;
			3'h6: db = 8'h28;
			default: db = 8'h2a;
		endcase
		return db;
	endfunction : acsc_target_db

	function automatic logic [7:0] acsc_rel_db(input logic [1:0] code);
		logic [7:0] db;
		db = REL_RISE_DB1;
		case (code)
			2'h2: db = REL_RISE_DB2;
			2'h3: db = REL_RISE_DB3;
			default: db = REL_RISE_DB1;
		endcase
		return db;
	endfunction : acsc_rel_db

endpackage : acsc_pkg

/* File: design/acsc_cs_detect.sv */
/*
 * Carrier sense detector: relative rise over a tracked RSSI floor and an absolute
 * threshold offset from the amplitude target.
 * Assumes RSSI in dB on the device clock, qualified by a valid strobe.
 */
`timescale 1ns/100ps
module acsc_cs_detect
	import acsc_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] rssi,
	input wire logic rssi_valid,
	input wire logic [1:0] cs_relative_threshold,
	input wire logic [3:0] cs_absolute_threshold,
	input wire logic [7:0] target_db,
	output logic carrier_sense_r
);
	logic [7:0] floor_r;
	logic floor_valid_r;
	logic rel_en;
	logic abs_en;
	logic rel_hit;
	logic abs_hit;
	logic signed [9:0] abs_thr;
	logic signed [9:0] rssi_s;
	logic [8:0] rise;
	logic cs_nxt;

	// Floor follows the quietest sample so a rise is measured against the noise level
	always_ff @(posedge clk) begin
		if (!nrst) begin
			floor_r <= 8'h00;
			floor_valid_r <= 1'b0;
		end else if (rssi_valid && (!floor_valid_r || rssi < floor_r)) begin
			floor_r <= rssi;
			floor_valid_r <= 1'b1;
		end
	end

	always_comb begin
		rel_en = cs_relative_threshold != REL_THR_DISABLED;
		abs_en = cs_absolute_threshold != ABS_THR_DISABLED;
		rise = {1'b0, rssi} - {1'b0, floor_r};
		rel_hit = floor_valid_r && !rise[8] && (rise[7:0] >= acsc_rel_db(cs_relative_threshold));
		// minus 7 to plus 7 dB
		abs_thr = $signed({2'b00, target_db}) + $signed({{6{cs_absolute_threshold[3]}},
			cs_absolute_threshold});
		rssi_s = $signed({2'b00, rssi});
		abs_hit = rssi_s >= abs_thr;
		cs_nxt = (rel_en && rel_hit) || (abs_en && abs_hit);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			carrier_sense_r <= 1'b0;
		end else if (!rel_en && !abs_en) begin
			carrier_sense_r <= 1'b0;
		end else if (rssi_valid) begin
			carrier_sense_r <= cs_nxt;
		end
	end

	both_disabled_a: assert property (@(posedge clk) disable iff (!nrst)
		(!rel_en && !abs_en) |=> !carrier_sense_r)
		else $error("carrier sense raised with both criteria off");

	abs_at_target_a: assert property (@(posedge clk) disable iff (!nrst)
		(rssi_valid && cs_absolute_threshold == 4'h0 && !rel_en && rssi == target_db)
		|=> carrier_sense_r)
		else $error("carrier sense missing at target level");

	abs_disabled_a: assert property (@(posedge clk) disable iff (!nrst)
		(rssi_valid && !rel_en && cs_absolute_threshold == ABS_THR_DISABLED)
		|=> !carrier_sense_r)
		else $error("absolute criterion active while disabled");

	rel_rise_a: assert property (@(posedge clk) disable iff (!nrst)
		(rssi_valid && cs_relative_threshold == 2'h1 && floor_valid_r && rssi >= floor_r
		&& (rssi - floor_r) >= REL_RISE_DB1) |=> carrier_sense_r)
		else $error("relative rise not sensed");

	cs_seen_c: cover property (@(posedge clk) disable iff (!nrst) $rose(carrier_sense_r));

endmodule : acsc_cs_detect

/* File: design/acsc_regs.sv */
/*
 * Gain control and carrier sense configuration bank with the gain stepping,
 * carrier sense and clear channel logic that the fields steer.
 * Assumes the serial control logic presents byte accesses on the device clock,
 * and that rssi, packet status and gain requests come from logic on that clock.
 */
`timescale 1ns/100ps
module acsc_regs
	import acsc_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] rssi,
	input wire logic rssi_valid,
	input wire logic pkt_receiving,
	input wire logic [1:0] clear_channel_select,
	input wire logic gain_up,
	input wire logic gain_down,
	output acsc_gain_t gain_out,
	output logic [7:0] amplitude_target_db,
	output logic carrier_sense,
	output logic channel_clear,
	output logic [7:0] freq_offset_cfg,
	output logic [7:0] bit_sync_cfg
);
	logic [7:0] foc_r;
	logic [7:0] bsync_r;
	acsc_limits_t limits_r;
	acsc_csense_t csense_r;
	acsc_gain_t gain_r;
	logic [7:0] target_db_r;
	logic channel_clear_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [2:0] digital_variable_amp_cap;
	logic [3:0] lna_cap;
	logic [3:0] lna_sum;
	acsc_gain_t gain_nxt;
	logic cs_r;

	// Register writes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			foc_r <= RST_FREQ_OFFSET;
			bsync_r <= RST_BIT_SYNC;
			limits_r <= RST_GAIN_LIMITS;
			csense_r <= RST_CARRIER_SENSE;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_FREQ_OFFSET: foc_r <= reg_wdata & MASK_FREQ_OFFSET;
				ADDR_BIT_SYNC: bsync_r <= reg_wdata;
				ADDR_GAIN_LIMITS: limits_r <= reg_wdata;
				ADDR_CARRIER_SENSE: csense_r <= reg_wdata & MASK_CARRIER_SENSE;
				default: begin
				end
			endcase
		end
	end

	// Read data; unmapped addresses answer zero
	always_comb begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			ADDR_FREQ_OFFSET: rdata_nxt = foc_r;
			ADDR_BIT_SYNC: rdata_nxt = bsync_r;
			ADDR_GAIN_LIMITS: rdata_nxt = limits_r;
			ADDR_CARRIER_SENSE: rdata_nxt = csense_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			target_db_r <= acsc_target_db(RST_GAIN_LIMITS[2:0]);
		end else begin
			target_db_r <= acsc_target_db(limits_r.amplitude_target);
		end
	end

	always_comb begin
		digital_variable_amp_cap = GAIN_STEP_MAX - {1'b0, limits_r.digital_gain_ceiling};
		lna_cap = LNA_SUM_MAX - 4'({limits_r.amplifier_gain_ceiling, 1'b0});
		lna_sum = {1'b0, gain_r.low_noise_amp1} + {1'b0, gain_r.low_noise_amp2};
		gain_nxt = gain_r;
		if (gain_r.digital_variable_amp > digital_variable_amp_cap) begin
			// A lowered ceiling wins over any request
			gain_nxt.digital_variable_amp = digital_variable_amp_cap;
		end else if (lna_sum > lna_cap || gain_down) begin
			if (gain_r.low_noise_amp1 == GAIN_STEP_MIN && gain_r.low_noise_amp2 == GAIN_STEP_MIN) begin
				if (gain_r.digital_variable_amp != GAIN_STEP_MIN) begin
					gain_nxt.digital_variable_amp = gain_r.digital_variable_amp - 3'h1;
				end
			end else if (csense_r.gain_reduction_order) begin
				if (gain_r.low_noise_amp1 != GAIN_STEP_MIN) begin
					gain_nxt.low_noise_amp1 = gain_r.low_noise_amp1 - 3'h1;
				end else begin
					gain_nxt.low_noise_amp2 = gain_r.low_noise_amp2 - 3'h1;
				end
			end else begin
				if (gain_r.low_noise_amp2 != GAIN_STEP_MIN) begin
					gain_nxt.low_noise_amp2 = gain_r.low_noise_amp2 - 3'h1;
				end else begin
					gain_nxt.low_noise_amp1 = gain_r.low_noise_amp1 - 3'h1;
				end
			end
		end else if (gain_up) begin
			// Analog stages first on the way up, digital gain last
			if (lna_sum < lna_cap && gain_r.low_noise_amp1 != GAIN_STEP_MAX) begin
				gain_nxt.low_noise_amp1 = gain_r.low_noise_amp1 + 3'h1;
			end else if (lna_sum < lna_cap && gain_r.low_noise_amp2 != GAIN_STEP_MAX) begin
				gain_nxt.low_noise_amp2 = gain_r.low_noise_amp2 + 3'h1;
			end else if (gain_r.digital_variable_amp < digital_variable_amp_cap) begin
				gain_nxt.digital_variable_amp = gain_r.digital_variable_amp + 3'h1;
			end
		end
	end

	// Gain starts at minimum so a fresh receiver never overdrives
	always_ff @(posedge clk) begin
		if (!nrst) begin
			gain_r <= '0;
		end else begin
			gain_r <= gain_nxt;
		end
	end

	acsc_cs_detect u_cs_detect (
		.clk(clk),
		.nrst(nrst),
		.rssi(rssi),
		.rssi_valid(rssi_valid),
		.cs_relative_threshold(csense_r.cs_relative_threshold),
		.cs_absolute_threshold(csense_r.cs_absolute_threshold),
		.target_db(target_db_r),
		.carrier_sense_r(cs_r)
	);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			channel_clear_r <= 1'b0;
		end else begin
			case (clear_channel_select)
				CCA_ALWAYS: channel_clear_r <= 1'b1;
				CCA_RSSI: channel_clear_r <= !cs_r;
				CCA_NO_PACKET: channel_clear_r <= !pkt_receiving;
				CCA_RSSI_NO_PACKET: channel_clear_r <= !cs_r && !pkt_receiving;
				default: channel_clear_r <= 1'b0;
			endcase
		end
	end

	assign reg_rdata = rdata_r;
	assign gain_out = gain_r;
	assign amplitude_target_db = target_db_r;
	assign carrier_sense = cs_r;
	assign channel_clear = channel_clear_r;
	assign freq_offset_cfg = foc_r;
	assign bit_sync_cfg = bsync_r;

	digital_variable_amp_ceiling_a: assert property (@(posedge clk) disable iff (!nrst)
		##1 gain_r.digital_variable_amp > digital_variable_amp_cap |=> gain_r.digital_variable_amp == $past(digital_variable_amp_cap))
		else $error("digital gain above its ceiling");

	lna_cap_a: assert property (@(posedge clk) disable iff (!nrst)
		(lna_sum > lna_cap && gain_r.digital_variable_amp <= digital_variable_amp_cap) |=> lna_sum < $past(lna_sum))
		else $error("amplifier gain not brought under the cap");

	target_map_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_wr && reg_addr == ADDR_GAIN_LIMITS && reg_wdata[2:0] == 3'h5)
		|=> ##1 target_db_r == 8'h26)
		else $error("amplitude target mapped wrongly");

	order_first_a: assert property (@(posedge clk) disable iff (!nrst)
		(gain_down && csense_r.gain_reduction_order && gain_r.low_noise_amp1 != GAIN_STEP_MIN
		&& gain_r.digital_variable_amp <= digital_variable_amp_cap)
		|=> gain_r.low_noise_amp1 == $past(gain_r.low_noise_amp1) - 3'h1
		&& gain_r.low_noise_amp2 == $past(gain_r.low_noise_amp2))
		else $error("first stage not reduced first");

	order_second_a: assert property (@(posedge clk) disable iff (!nrst)
		(gain_down && !csense_r.gain_reduction_order && gain_r.low_noise_amp2 != GAIN_STEP_MIN
		&& gain_r.digital_variable_amp <= digital_variable_amp_cap)
		|=> gain_r.low_noise_amp1 == $past(gain_r.low_noise_amp1))
		else $error("first stage touched before second drained");

	foc_readback_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_wr && reg_addr == ADDR_FREQ_OFFSET) ##1 (reg_rd && reg_addr == ADDR_FREQ_OFFSET
		&& !reg_wr) |=> reg_rdata == ($past(reg_wdata, 2) & MASK_FREQ_OFFSET))
		else $error("frequency offset readback wrong");

	bsync_readback_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_wr && reg_addr == ADDR_BIT_SYNC) |=> bit_sync_cfg == $past(reg_wdata))
		else $error("bit sync write lost");

	reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		##1 (reg_rd && reg_addr == ADDR_CARRIER_SENSE) |=> !reg_rdata[7])
		else $error("reserved bit reads one");

	cca_mode3_a: assert property (@(posedge clk) disable iff (!nrst)
		(clear_channel_select == CCA_RSSI_NO_PACKET && (cs_r || pkt_receiving)) |=> !channel_clear)
		else $error("channel clear during carrier or packet");

	cs_follow_a: assert property (@(posedge clk) disable iff (!nrst)
		(clear_channel_select == CCA_RSSI) |=> channel_clear == !$past(cs_r))
		else $error("clear channel disagrees with carrier sense");

	reduce_c: cover property (@(posedge clk) disable iff (!nrst) gain_down ##1 $fell(gain_r.low_noise_amp1[0]));
	clear_c: cover property (@(posedge clk) disable iff (!nrst)
		clear_channel_select == CCA_RSSI_NO_PACKET ##1 channel_clear);
	write_c: cover property (@(posedge clk) disable iff (!nrst) reg_wr && reg_addr == ADDR_CARRIER_SENSE);

endmodule : acsc_regs

/* File: verif/acsc_regs_tb.sv */
/*
 * Self-checking bench for the gain control and carrier sense configuration bank.
 * Assumes the byte register port of acsc_regs; the bench drives every input itself.
 */
`timescale 1ns/100ps
module acsc_regs_tb
	import acsc_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] rssi = 8'h00;
	logic rssi_valid = 1'b0;
	logic pkt_receiving = 1'b0;
	logic [1:0] clear_channel_select = 2'h0;
	logic gain_up = 1'b0;
	logic gain_down = 1'b0;
	acsc_gain_t gain_out;
	logic [7:0] amplitude_target_db;
	logic carrier_sense;
	logic channel_clear;
	logic [7:0] freq_offset_cfg;
	logic [7:0] bit_sync_cfg;
	int fail_count = 0;
	int checks_done = 0;
	logic [7:0] q;
	logic [7:0] addrs [5] = '{8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d};
	logic [7:0] rsts [5] = '{8'h36, 8'h6c, 8'h03, 8'h40, 8'h00};
	logic [7:0] masks [5] = '{8'h3f, 8'hff, 8'hff, 8'h7f, 8'h00};
	logic [7:0] tgt [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
	logic [3:0] abs_codes [3] = '{4'h9, 4'h0, 4'h7};
	logic [7:0] rises [3] = '{8'h06, 8'h0a, 8'h0e};
	logic [7:0] thr;

	always #2 clk = ~clk;

	acsc_regs dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rssi(rssi),
		.rssi_valid(rssi_valid), .pkt_receiving(pkt_receiving),
		.clear_channel_select(clear_channel_select), .gain_up(gain_up),
		.gain_down(gain_down), .gain_out(gain_out),
		.amplitude_target_db(amplitude_target_db), .carrier_sense(carrier_sense),
		.channel_clear(channel_clear), .freq_offset_cfg(freq_offset_cfg),
		.bit_sync_cfg(bit_sync_cfg));

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask : check

	// Every task starts and ends just after a rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// Idle cycle after each strobe keeps the strobe from being set twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step(1);
		reg_wr = 1'b0;
		step(1);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		step(1);
		reg_rd = 1'b0;
		d = reg_rdata;
		step(1);
	endtask : rd

	function automatic logic [3:0] gsum();
		return {1'b0, gain_out.low_noise_amp1} + {1'b0, gain_out.low_noise_amp2};
	endfunction : gsum

	task automatic gain_wait(input logic [2:0] dv, input logic [3:0] sm);
		int i;
		for (i = 0; i < 40; i++) begin
			if (gain_out.digital_variable_amp === dv && gsum() === sm) break;
			step(1);
		end
		check("gain_digital_variable_amp", {6'h00, gain_out.digital_variable_amp}, {6'h00, dv});
		check("gain_lna_sum", {5'h00, gsum()}, {5'h00, sm});
		// A wait that runs out counts as a mismatch even if the last sample matched
		if (i == 40) begin
			$display("[FAIL] gain_wait expected settle seen timeout");
			fail_count++;
			conclude();
		end
	endtask : gain_wait

	// One valid RSSI sample under a given carrier sense setting
	task automatic cs_try(input logic [7:0] cfg, input logic [7:0] r, input logic e);
		wr(8'h1c, cfg);
		rssi = r;
		rssi_valid = 1'b1;
		step(1);
		rssi_valid = 1'b0;
		step(1);
		check("carrier_sense", {8'h00, carrier_sense}, {8'h00, e});
	endtask : cs_try

	initial begin
		step(2);
		nrst = 1'b1;
		check("gain_out_rst", gain_out, 9'h000);
		check("cs_rst", {8'h00, carrier_sense}, 9'h000);
		check("freq_offset_cfg_rst", {1'b0, freq_offset_cfg}, 9'h036);
		check("bit_sync_cfg_rst", {1'b0, bit_sync_cfg}, 9'h06c);
		check("target_rst", {1'b0, amplitude_target_db}, 9'h021);
		for (int k = 0; k < 5; k++) begin
			rd(addrs[k], q);
			check("reg_reset", {1'b0, q}, {1'b0, rsts[k]});
		end
		foreach (abs_codes[p]) begin
			for (int k = 0; k < 5; k++) wr(addrs[k], p[0] ? 8'ha5 : 8'hff);
			for (int k = 0; k < 5; k++) begin
				rd(addrs[k], q);
				check("reg_rw", {1'b0, q}, {1'b0, masks[k] & (p[0] ? 8'ha5 : 8'hff)});
			end
		end
		check("freq_offset_cfg", {1'b0, freq_offset_cfg}, 9'h03f);
		check("bit_sync_cfg", {1'b0, bit_sync_cfg}, 9'h0ff);
		for (int c = 0; c < 8; c++) begin
			wr(8'h1b, {5'h00, c[2:0]});
			step(1);
			check("amplitude_target_db", {1'b0, amplitude_target_db}, {1'b0, tgt[c]});
		end
		// ceilings: amplifier ceiling tightened one code at a time, digital ceiling stepping 0 to 3 twice
		gain_up = 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(8'h1b, {c[1:0], c[2:0], 3'h3});
			gain_wait(3'h7 - {1'b0, c[1:0]}, 4'he - {c[2:0], 1'b0});
		end
		// reduction order, from full gain each time
		foreach (abs_codes[p]) begin
			if (p < 2) begin
				wr(8'h1b, 8'h03);
				wr(8'h1c, {1'b0, ~p[0], 6'h08});
				gain_up = 1'b1;
				gain_wait(3'h7, 4'he);
				gain_up = 1'b0;
				gain_down = 1'b1;
				step(8);
				gain_down = 1'b0;
				step(2);
				check("lna1", {6'h00, gain_out.low_noise_amp1}, p[0] ? 9'h006 : 9'h000);
				check("lna2", {6'h00, gain_out.low_noise_amp2}, p[0] ? 9'h000 : 9'h006);
			end
		end
		// both criteria off; the first sample also sets the floor to 0x10
		cs_try(8'h08, 8'h10, 1'b0);
		cs_try(8'h08, 8'hff, 1'b0);
		// signed offset from the 33 dB target
		foreach (abs_codes[k]) begin
			thr = 8'h21 + {{4{abs_codes[k][3]}}, abs_codes[k]};
			cs_try({4'h0, abs_codes[k]}, thr, 1'b1);
			cs_try({4'h0, abs_codes[k]}, thr - 8'h01, 1'b0);
		end
		foreach (rises[k]) begin
			cs_try({2'h0, 2'(k + 1), 4'h8}, 8'h10 + rises[k], 1'b1);
			cs_try({2'h0, 2'(k + 1), 4'h8}, 8'h0f + rises[k], 1'b0);
		end
		for (int m = 0; m < 16; m++) begin
			clear_channel_select = m[3:2];
			pkt_receiving = m[0];
			cs_try(8'h00, m[1] ? 8'h21 : 8'h11, m[1]);
			check("channel_clear", {8'h00, channel_clear}, {8'h00, (m[3:2] == 2'h0)
				|| (m[3:2] == 2'h1 && !m[1]) || (m[3:2] == 2'h2 && !m[0])
				|| (m[3:2] == 2'h3 && !m[1] && !m[0])});
		end
		conclude();
	end
endmodule : acsc_regs_tb
